// ===== irq_bank.sv
`timescale 1ns/1ps
module irq_bank
    import modem_regs_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    input  wire logic [N-1:0] event_i,
    input  wire logic         clear_we_i,
    input  wire logic         enable_we_i,
    input  wire logic [N-1:0] wdata_i,
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] enable_o,
    output logic              irq_o
);

    logic [N-1:0] status_r;
    logic [N-1:0] enable_r;
    logic [N-1:0] status_nxt;
    logic         irq_r;

    // Set beats clear so an event in the clear cycle survives
    assign status_nxt = (status_r & ~(clear_we_i ? wdata_i : '0)) | event_i;

    // Sticky status
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) status_r <= '0;
        else        status_r <= status_nxt;
    end

    // Enable mask
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)           enable_r <= '0;
        else if (enable_we_i) enable_r <= wdata_i;
    end

    // Level output from a flop
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) irq_r <= 1'b0;
        else        irq_r <= |(status_nxt & (enable_we_i ? wdata_i : enable_r));
    end

    assign status_o = status_r;
    assign enable_o = enable_r;
    assign irq_o    = irq_r;

endmodule : irq_bank

// ===== modem_partner.sv
`timescale 1ns/1ps
module modem_partner
    import modem_regs_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire modem_bits_s want_i,
    input  wire logic [3:0]  lag_i,
    output logic             cd_n_o,
    output logic             ri_n_o,
    output logic             dsr_n_o,
    output logic             cts_n_o
);
    logic [3:0]  wait_r = 4'h0;
    modem_bits_s held_r = '0;

    // Lines follow the request lag_i+1 cycles later; a slow modem settles late
    always @(posedge sys_clk_i) begin
        if (want_i != held_r && wait_r < lag_i) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            wait_r <= 4'h0;
            held_r <= want_i;
        end
    end

    // Lines are active low and idle high
    assign {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~held_r;
endmodule : modem_partner

// ===== modem_regs_pkg.sv
// Contract
// (R01) Line state read-only, shares select address
// (R02) Write there loads select, not status
// (R03) Bit7: carrier inverse, loopback control bit3
// (R04) Bit6: ring inverse, loopback control bit2
// (R05) Bit5: set-ready inverse, loopback control bit0
// (R06) Bit4: clear-to-send inverse, loopback bit1
// (R07) Bits3,1,0 flag any level change
// (R08) Ring flag only on input rising
// (R09) Read clears flags; reset clears flags
// (R10) Interrupt request while any flag set
// (R11) Select register write-only, bits 7:3 reserved
// (R12) Bits2:1 choose visible register set
// (R13) Bit0 enables level counter reads
// (R14) Set select overrides level enable
// (R15) Scratch byte stores and returns eight bits
// (R16) Divisor in high and low latches
// (R17) Transmit count reports free entries
// (R18) Receive count reports held characters
// (R19) Synchronise modem inputs before change detection
package modem_regs_pkg;

    localparam int          ADR_W          = 8;
    localparam int          DAT_W          = 32;
    localparam int          SEL_W          = 4;
    localparam int          SYNC_STAGES    = 2;
    localparam int          N_EVENTS       = 4;

    // Word-aligned byte offsets
    localparam logic [7:0]  OFF_LINE_STATE = 8'h00;
    localparam logic [7:0]  OFF_SCRATCH    = 8'h04;
    localparam logic [7:0]  OFF_DIV_LOW    = 8'h08;
    localparam logic [7:0]  OFF_DIV_HIGH   = 8'h0c;
    localparam logic [7:0]  OFF_TX_FREE    = 8'h10;
    localparam logic [7:0]  OFF_RX_FILL    = 8'h14;
    localparam logic [7:0]  OFF_MODEM_CTRL = 8'h18;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_CLEAR  = 8'h20;
    localparam logic [7:0]  OFF_IRQ_ENABLE = 8'h24;

    // Modem control register fields
    localparam int          MCR_DTR        = 0;
    localparam int          MCR_RTS        = 1;
    localparam int          MCR_OUT1       = 2;
    localparam int          MCR_OUT2       = 3;
    localparam int          MCR_LOOP       = 4;

    // Extra feature select fields and set codes
    localparam int          SEL_LVL_EN     = 0;
    localparam int          SEL_SET_LO     = 1;
    localparam int          SEL_SET_HI     = 2;
    localparam logic [1:0]  SET_GENERAL    = 2'h0;
    localparam logic [1:0]  SET_EXTRA_ONE  = 2'h1;
    localparam logic [1:0]  SET_EXTRA_TWO  = 2'h2;

    // Change flag and event positions
    localparam int          EV_CTS         = 0;
    localparam int          EV_DSR         = 1;
    localparam int          EV_RI          = 2;
    localparam int          EV_CD          = 3;

    // Values after reset
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [3:0]  RST_FLAGS      = 4'h0;
    localparam logic [3:0]  RST_PINS_N     = 4'hf;

    // Modem lines, active high, in status bit order 7..4
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_bits_s;

endpackage : modem_regs_pkg

// ===== modem_regs_properties.sv
`timescale 1ns/1ps
module modem_regs_properties
    import modem_regs_pkg::*;
(
    input wire logic             sys_clk_i,
    input wire logic             srst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    input wire logic [DAT_W-1:0] wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             cd_n_i,
    input wire logic             dsr_n_i,
    input wire logic             cts_n_i,
    input wire logic [7:0]       tx_free_i,
    input wire logic [7:0]       rx_fill_i,
    input wire logic             dtr_n_o,
    input wire logic             rts_n_o,
    input wire logic             out1_n_o,
    input wire logic             out2_n_o,
    input wire logic [1:0]       reg_set_sel_o,
    input wire logic             level_cnt_en_o,
    input wire logic [15:0]      baud_divisor_o,
    input wire logic             modem_irq_o
);
    // Single clock domain; reset silences every check
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    // Qualified bus answers
    logic rd_ack;
    logic wr_ack;
    logic looped_off;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
    // All outputs idle in loopback, so this only guards normal mode
    assign looped_off = !(dtr_n_o && rts_n_o && out1_n_o && out2_n_o);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_write_keeps_data: assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
        else $error("write disturbed read data");
    a_status_irq_match: assert property (rd_ack && wb_adr_i == OFF_LINE_STATE
        |-> $past(modem_irq_o) == (|wb_dat_o[3:0])) else $error("modem irq differs from flags");
    a_level_gate: assert property (level_cnt_en_o |-> reg_set_sel_o == SET_GENERAL)
        else $error("level enable outside general set");
    a_select_load: assert property (wr_ack && wb_adr_i == OFF_LINE_STATE |=>
        reg_set_sel_o == $past(wb_dat_i[2:1])
        && level_cnt_en_o == ($past(wb_dat_i[0]) && $past(wb_dat_i[2:1]) == 2'h0))
        else $error("select outputs wrong after write");
    a_div_low: assert property (wr_ack && wb_adr_i == OFF_DIV_LOW
        |=> baud_divisor_o[7:0] == $past(wb_dat_i[7:0])) else $error("divisor low wrong");
    a_tx_gate: assert property (rd_ack && wb_adr_i == OFF_TX_FREE
        |-> wb_dat_o == {24'h0, $past(level_cnt_en_o) ? $past(tx_free_i) : 8'h00})
        else $error("tx free read wrong");
    a_rx_gate: assert property (rd_ack && wb_adr_i == OFF_RX_FILL
        |-> wb_dat_o == {24'h0, $past(level_cnt_en_o) ? $past(rx_fill_i) : 8'h00})
        else $error("rx fill read wrong");
    a_flag_on_change: assert property (looped_off
        && ($changed(cts_n_i) || $changed(dsr_n_i) || $changed(cd_n_i))
        |-> ##[1:4] modem_irq_o) else $error("pin change raised no flag");
endmodule : modem_regs_properties

bind modem_status_and_extra_regs modem_regs_properties u_props (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cd_n_i(cd_n_i), .dsr_n_i(dsr_n_i),
    .cts_n_i(cts_n_i), .tx_free_i(tx_free_i), .rx_fill_i(rx_fill_i), .dtr_n_o(dtr_n_o),
    .rts_n_o(rts_n_o), .out1_n_o(out1_n_o), .out2_n_o(out2_n_o),
    .reg_set_sel_o(reg_set_sel_o), .level_cnt_en_o(level_cnt_en_o),
    .baud_divisor_o(baud_divisor_o), .modem_irq_o(modem_irq_o)
);

// ===== modem_status_and_extra_regs.sv
`timescale 1ns/1ps
module modem_status_and_extra_regs
    import modem_regs_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    // Wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [SEL_W-1:0] wb_sel_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    output logic      [DAT_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    // Modem control pins, active low, asynchronous
    input  wire logic             cd_n_i,
    input  wire logic             ri_n_i,
    input  wire logic             dsr_n_i,
    input  wire logic             cts_n_i,
    // FIFO levels from the same clock domain
    input  wire logic [7:0]       tx_free_i,
    input  wire logic [7:0]       rx_fill_i,
    // Modem control pins driven out, active low
    output logic                  dtr_n_o,
    output logic                  rts_n_o,
    output logic                  out1_n_o,
    output logic                  out2_n_o,
    // Configuration towards the rest of the channel
    output logic      [1:0]       reg_set_sel_o,
    output logic                  level_cnt_en_o,
    output logic      [15:0]      baud_divisor_o,
    // Interrupts
    output logic                  modem_irq_o,
    output logic                  irq_o
);

    // Bus handshake
    logic              ack_r;
    logic [DAT_W-1:0]  dat_r;
    logic              req;
    logic              take;
    logic              wr_take;
    logic              rd_take;

    // Registers
    logic [7:0]        select_r;
    logic [7:0]        scratch_r;
    logic [7:0]        div_low_r;
    logic [7:0]        div_high_r;
    logic [7:0]        mcr_r;
    logic [3:0]        flags_r;
    logic [3:0]        flags_nxt;
    logic              modem_irq_r;

    // Pin side
    logic [3:0]        pins_n_sync;
    modem_bits_s       line_pin;
    modem_bits_s       line_now;
    modem_bits_s       line_prev_r;
    logic              loop_mode;

    // Change detection
    logic [3:0]        flag_set;
    logic              rd_line_state;

    // Read path
    logic [7:0]        rd_byte;
    logic              lvl_access;

    // Interrupt bank
    logic [N_EVENTS-1:0] irq_status;
    logic [N_EVENTS-1:0] irq_enable;
    logic                irq_bank_out;
    logic                irq_clear_we;
    logic                irq_enable_we;

    // Output flops for pins and config
    logic [3:0]        pins_out_r;
    logic [1:0]        set_sel_r;
    logic              lvl_en_r;
    logic [15:0]       divisor_r;

    //------------------------------------------------------------------
    // Wishbone slave
    //------------------------------------------------------------------

    // A request is taken once; ack drops the cycle after it rose
    assign req     = wb_cyc_i & wb_stb_i;
    assign take    = req & ~ack_r;
    assign wr_take = take & wb_we_i & wb_sel_i[0];
    assign rd_take = take & ~wb_we_i;

    // One-cycle ack for every address, mapped or not
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) ack_r <= 1'b0;
        else        ack_r <= take;
    end

    //------------------------------------------------------------------
    // Modem input path
    //------------------------------------------------------------------

    // (R19) two-flop synchronisers
    pin_sync #(
        .W       (4),
        .RST_VAL (RST_PINS_N)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .async_i   ({cd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
        .sync_o    (pins_n_sync)
    );

    // Pins are active low; status shows them active high
    assign line_pin  = modem_bits_s'(~pins_n_sync);
    assign loop_mode = mcr_r[MCR_LOOP];

    // Effective line state, pins or looped-back controls
    always_comb begin
        line_now = line_pin;
        if (loop_mode) begin
            // (R03) carrier from control bit 3
            line_now.cd  = mcr_r[MCR_OUT2];
            // (R04) ring from control bit 2
            line_now.ri  = mcr_r[MCR_OUT1];
            // (R05) set-ready from control bit 0
            line_now.dsr = mcr_r[MCR_DTR];
            // (R06) clear-to-send from control bit 1
            line_now.cts = mcr_r[MCR_RTS];
        end
    end

    // Previous effective state for edge detection
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) line_prev_r <= '0;
        else        line_prev_r <= line_now;
    end

    // Edge comparison on synchronised pin values or looped-back control bits only
    always_comb begin
        flag_set = '0;
        // (R07) any change of carrier, set-ready, clear-to-send
        flag_set[EV_CD]  = line_now.cd  ^ line_prev_r.cd;
        flag_set[EV_DSR] = line_now.dsr ^ line_prev_r.dsr;
        flag_set[EV_CTS] = line_now.cts ^ line_prev_r.cts;
        // (R08) ring pin going 0 to 1 only
        flag_set[EV_RI]  = line_prev_r.ri & ~line_now.ri;
    end

    //------------------------------------------------------------------
    // Change flags
    //------------------------------------------------------------------

    // (R01) line state decoded at the shared offset, reads only
    assign rd_line_state = rd_take & (wb_adr_i == OFF_LINE_STATE);

    // (R09) read clears, but a new change in that cycle wins
    assign flags_nxt = (flags_r & ~{4{rd_line_state}}) | flag_set;

    // (R09) flags zero after reset
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) flags_r <= RST_FLAGS;
        else        flags_r <= flags_nxt;
    end

    // (R10) request held while any flag is set
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) modem_irq_r <= 1'b0;
        else        modem_irq_r <= |flags_nxt;
    end

    //------------------------------------------------------------------
    // Writable registers
    //------------------------------------------------------------------

    // (R02) shared-offset write goes to the select register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            select_r <= RST_BYTE;
        end else if (wr_take && wb_adr_i == OFF_LINE_STATE) begin
            // (R11) reserved upper bits stored, never read back
            select_r <= wb_dat_i[7:0];
        end
    end

    // (R15) scratch byte, no side effect
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            scratch_r <= RST_BYTE;
        end else if (wr_take && wb_adr_i == OFF_SCRATCH) begin
            scratch_r <= wb_dat_i[7:0];
        end
    end

    // (R16) divisor low latch
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            div_low_r <= RST_BYTE;
        end else if (wr_take && wb_adr_i == OFF_DIV_LOW) begin
            div_low_r <= wb_dat_i[7:0];
        end
    end

    // (R16) divisor high latch
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            div_high_r <= RST_BYTE;
        end else if (wr_take && wb_adr_i == OFF_DIV_HIGH) begin
            div_high_r <= wb_dat_i[7:0];
        end
    end

    // Modem control, also the loopback source
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mcr_r <= RST_BYTE;
        end else if (wr_take && wb_adr_i == OFF_MODEM_CTRL) begin
            mcr_r <= wb_dat_i[7:0];
        end
    end

    //------------------------------------------------------------------
    // Interrupt bank: one event per change flag
    //------------------------------------------------------------------

    assign irq_clear_we  = wr_take & (wb_adr_i == OFF_IRQ_CLEAR);
    assign irq_enable_we = wr_take & (wb_adr_i == OFF_IRQ_ENABLE);

    irq_bank #(
        .N (N_EVENTS)
    ) u_irq_bank (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .event_i     (flag_set),
        .clear_we_i  (irq_clear_we),
        .enable_we_i (irq_enable_we),
        .wdata_i     (wb_dat_i[N_EVENTS-1:0]),
        .status_o    (irq_status),
        .enable_o    (irq_enable),
        .irq_o       (irq_bank_out)
    );

    //------------------------------------------------------------------
    // Read path
    //------------------------------------------------------------------

    // (R14) counters visible only in the general set
    assign lvl_access = select_r[SEL_LVL_EN]
                      & (select_r[SEL_SET_HI:SEL_SET_LO] == SET_GENERAL);

    // Read multiplexer; unmapped and write-only offsets give zero
    always_comb begin
        rd_byte = 8'h00;
        case (wb_adr_i)
            OFF_LINE_STATE: begin
                // (R01) status, never the select register
                rd_byte = {line_now, flags_r};
            end
            OFF_SCRATCH: begin
                // (R15) returned unchanged
                rd_byte = scratch_r;
            end
            OFF_DIV_LOW: begin
                rd_byte = div_low_r;
            end
            OFF_DIV_HIGH: begin
                rd_byte = div_high_r;
            end
            OFF_TX_FREE: begin
                // (R13) (R17) free transmit entries when enabled
                rd_byte = lvl_access ? tx_free_i : 8'h00;
            end
            OFF_RX_FILL: begin
                // (R13) (R18) held receive characters when enabled
                rd_byte = lvl_access ? rx_fill_i : 8'h00;
            end
            OFF_MODEM_CTRL: begin
                rd_byte = mcr_r;
            end
            OFF_IRQ_STATUS: begin
                rd_byte = {4'h0, irq_status};
            end
            OFF_IRQ_ENABLE: begin
                rd_byte = {4'h0, irq_enable};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Read data captured at the taking edge, held until next read
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dat_r <= '0;
        end else if (rd_take) begin
            dat_r <= {24'h000000, rd_byte};
        end
    end

    //------------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------------

    // Pins idle high in loopback so the far end sees nothing
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pins_out_r <= RST_PINS_N;
        end else if (loop_mode) begin
            pins_out_r <= RST_PINS_N;
        end else begin
            pins_out_r <= ~{mcr_r[MCR_OUT2], mcr_r[MCR_OUT1],
                            mcr_r[MCR_RTS],  mcr_r[MCR_DTR]};
        end
    end

    // (R12) register set select passed to the channel
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            set_sel_r <= SET_GENERAL;
            lvl_en_r  <= 1'b0;
        end else begin
            set_sel_r <= select_r[SEL_SET_HI:SEL_SET_LO];
            lvl_en_r  <= lvl_access;
        end
    end

    // (R16) high latch is the upper byte
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) divisor_r <= 16'h0000;
        else        divisor_r <= {div_high_r, div_low_r};
    end

    assign wb_ack_o       = ack_r;
    assign wb_dat_o       = dat_r;
    assign dtr_n_o        = pins_out_r[0];
    assign rts_n_o        = pins_out_r[1];
    assign out1_n_o       = pins_out_r[2];
    assign out2_n_o       = pins_out_r[3];
    assign reg_set_sel_o  = set_sel_r;
    assign level_cnt_en_o = lvl_en_r;
    assign baud_divisor_o = divisor_r;
    assign modem_irq_o    = modem_irq_r;
    assign irq_o          = irq_bank_out;

endmodule : modem_status_and_extra_regs

// ===== modem_status_and_extra_regs_tb.sv
`timescale 1ns/1ps
module modem_status_and_extra_regs_tb;
    import modem_regs_pkg::*;
    logic             sys_clk_i = 1'b0;
    logic             srst_i = 1'b1;
    logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]       wb_adr_i = 8'h00, tx_free_i = 8'h00, rx_fill_i = 8'h00;
    logic [3:0]       wb_sel_i = 4'h0, lag = 4'h0;
    logic [31:0]      wb_dat_i = 32'h0, wb_dat_o, v;
    logic             wb_ack_o, cd_n, ri_n, dsr_n, cts_n, dtr_n_o, rts_n_o, out1_n_o, out2_n_o;
    logic [1:0]       reg_set_sel_o;
    logic             level_cnt_en_o, modem_irq_o, irq_o;
    logic [15:0]      baud_divisor_o;
    modem_bits_s      want = '0;
    logic [63:0]      exp_q [$];
    logic [63:0]      mon_e;
    logic [7:0]       offs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20,
                                    8'h24, 8'h30};
    int               bad_count = 0, checks_done = 0, seed = 32'h8506, en;

    always #5 sys_clk_i = ~sys_clk_i;

    modem_status_and_extra_regs uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cd_n_i(cd_n), .ri_n_i(ri_n), .dsr_n_i(dsr_n), .cts_n_i(cts_n),
        .tx_free_i(tx_free_i), .rx_fill_i(rx_fill_i), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
        .out1_n_o(out1_n_o), .out2_n_o(out2_n_o), .reg_set_sel_o(reg_set_sel_o),
        .level_cnt_en_o(level_cnt_en_o), .baud_divisor_o(baud_divisor_o),
        .modem_irq_o(modem_irq_o), .irq_o(irq_o));

    modem_partner u_modem (.sys_clk_i(sys_clk_i), .want_i(want), .lag_i(lag),
        .cd_n_o(cd_n), .ri_n_o(ri_n), .dsr_n_o(dsr_n), .cts_n_o(cts_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; request held until ack is seen
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel);
        int n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n == 20) begin
            bad_count++;
            $display("Error at %0t: no bus answer", $time);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 4'h1);
    endtask : wr

    // Expectation noted before the read; a zero mask discards the value
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
        exp_q.push_back({mask, exp});
        bus(1'b0, adr, 32'h0, 4'hf);
    endtask : rd

    task automatic pin_step(input modem_bits_s pv, input logic [3:0] fl, input logic [3:0] lg);
        want <= pv;
        lag  <= lg;
        repeat (12) @(posedge sys_clk_i);
        chk(modem_irq_o, fl != 4'h0, 32'h1);
        rd(OFF_LINE_STATE, {pv, fl}, '1);
        rd(OFF_LINE_STATE, {pv, 4'h0}, '1);
    endtask : pin_step

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Every read answer is matched against the oldest noted expectation
    always @(posedge sys_clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            mon_e = exp_q.pop_front();
            chk(wb_dat_o, mon_e[31:0], mon_e[63:32]);
        end
    end

    // Run takes about one thousand cycles
    initial begin
        #100000;
        bad_count++;
        $display("Error at %0t: watchdog", $time);
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk_i);
        srst_i    <= 1'b0;
        tx_free_i <= 8'h5a;
        rx_fill_i <= 8'ha5;
        foreach (offs[i]) rd(offs[i], 32'h0, '1);
        chk({dtr_n_o, rts_n_o, out1_n_o, out2_n_o, reg_set_sel_o, level_cnt_en_o,
             baud_divisor_o, modem_irq_o, irq_o}, {4'hf, 21'h0}, '1);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(OFF_SCRATCH, v);
            rd(OFF_SCRATCH, {24'h0, v[7:0]}, '1);
        end
        bus(1'b1, OFF_SCRATCH, ~v, 4'he);
        rd(OFF_SCRATCH, {24'h0, v[7:0]}, '1);
        v = $random(seed);
        wr(OFF_DIV_LOW, v[7:0]);
        wr(OFF_DIV_HIGH, v[15:8]);
        rd(OFF_DIV_HIGH, v[15:8], '1);
        chk(baud_divisor_o, v[15:0], 32'hffff);
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(OFF_LINE_STATE, {v[7:3], k[2:0]});
            tx_free_i <= v[15:8];
            rx_fill_i <= v[23:16];
            en = (k == 1);
            chk({reg_set_sel_o, level_cnt_en_o}, {k[2:1], en[0]}, '1);
            rd(OFF_TX_FREE, en ? v[15:8] : 8'h00, '1);
            rd(OFF_RX_FILL, en ? v[23:16] : 8'h00, '1);
            rd(OFF_LINE_STATE, 32'h0, '1);
        end
        wr(OFF_LINE_STATE, 32'h0);
        wr(OFF_MODEM_CTRL, 32'h1);
        pin_step(4'b0001, 4'b0001, 4'h0);
        pin_step(4'b0011, 4'b0010, 4'h5);
        pin_step(4'b1011, 4'b1000, 4'h0);
        pin_step(4'b1111, 4'b0000, 4'h2);
        pin_step(4'b0111, 4'b1000, 4'h3);
        pin_step(4'b0011, 4'b0100, 4'h0);
        pin_step(4'b0000, 4'b0011, 4'h4);
        rd(OFF_IRQ_STATUS, 32'hf, '1);
        chk(irq_o, 32'h0, 32'h1);
        wr(OFF_IRQ_ENABLE, 32'h1);
        chk(irq_o, 32'h1, 32'h1);
        rd(OFF_IRQ_ENABLE, 32'h1, '1);
        wr(OFF_IRQ_CLEAR, 32'h1);
        chk(irq_o, 32'h0, 32'h1);
        wr(OFF_IRQ_STATUS, 32'hf);
        rd(OFF_IRQ_STATUS, 32'he, '1);
        wr(OFF_IRQ_ENABLE, 32'h2);
        chk(irq_o, 32'h1, 32'h1);
        wr(OFF_IRQ_CLEAR, 32'hf);
        rd(OFF_IRQ_STATUS, 32'h0, '1);
        chk(irq_o, 32'h0, 32'h1);
        for (int m = 0; m < 32; m++) begin
            wr(OFF_MODEM_CTRL, m);
            repeat (6) @(posedge sys_clk_i);
            chk({dtr_n_o, rts_n_o, out1_n_o, out2_n_o},
                m[4] ? 4'hf : ~{m[0], m[1], m[2], m[3]}, 32'hf);
            rd(OFF_LINE_STATE, 32'h0, 32'h0);
            rd(OFF_LINE_STATE, m[4] ? {m[3], m[2], m[0], m[1], 4'h0} : 8'h00, '1);
        end
        close_out();
    end
endmodule : modem_status_and_extra_regs_tb

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync
    import modem_regs_pkg::*;
#(
    parameter int          W       = 4,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    // Two flops per bit; first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    meta_r <= RST_VAL[g];
                    hold_r <= RST_VAL[g];
                end else begin
                    meta_r <= async_i[g];
                    hold_r <= meta_r;
                end
            end
            assign sync_o[g] = hold_r;
        end
    endgenerate

endmodule : pin_sync
